//--- include/csds_pkg.sv
// constants and types for the region select decode and strobe block
package csds_pkg;

    // -----------------------------------------------------------------
    // geometry
    // -----------------------------------------------------------------
    localparam int unsigned CSDS_NREG     = 5;
    localparam logic [2:0]  CSDS_NREG_L   = 3'h5;

    // -----------------------------------------------------------------
    // register byte offsets (one 32-bit word each)
    // -----------------------------------------------------------------
    localparam logic [7:0]  CSDS_OFS_RGN_END = 8'h28; // regions below this
    localparam logic [7:0]  CSDS_OFS_CTRL    = 8'h28;
    localparam logic [7:0]  CSDS_OFS_STAT    = 8'h2c;
    localparam int unsigned CSDS_IDX_LO      = 3;     // region index bits
    localparam int unsigned CSDS_IDX_HI      = 5;
    localparam int unsigned CSDS_SEL_OPT     = 2;     // 0 start, 1 option

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int unsigned CSDS_F_EN     = 0;   // start word
    localparam int unsigned CSDS_F_PW_LO  = 2;   // option word [3:2]
    localparam int unsigned CSDS_F_PW_HI  = 3;
    localparam int unsigned CSDS_F_DRAM   = 4;
    localparam int unsigned CSDS_F_WT_LO  = 8;   // option word [11:8]
    localparam int unsigned CSDS_F_WT_HI  = 11;
    localparam int unsigned CSDS_F_HI_LO  = 12;  // start / mask [31:12]
    localparam int unsigned CSDS_F_TOPF   = 1;   // control word
    localparam int unsigned CSDS_F_SECF   = 0;

    // -----------------------------------------------------------------
    // encodings
    // -----------------------------------------------------------------
    localparam logic [1:0]  CSDS_PW_32    = 2'h0;
    localparam logic [1:0]  CSDS_PW_16    = 2'h1;
    localparam logic [1:0]  CSDS_PW_8     = 2'h2;
    localparam logic [1:0]  CSDS_PW_32X   = 2'h3;
    localparam logic [1:0]  CSDS_SZ_BYTE  = 2'h0;
    localparam logic [1:0]  CSDS_SZ_HALF  = 2'h1;
    localparam logic [1:0]  CSDS_SZ_WORD  = 2'h2;

    // -----------------------------------------------------------------
    // boot strap values and reset values
    // -----------------------------------------------------------------
    localparam logic [1:0]  CSDS_STRAP_OFF  = 2'h0;
    localparam logic [1:0]  CSDS_STRAP_SRAM = 2'h1;
    localparam logic [1:0]  CSDS_STRAP_DRAM = 2'h2;
    localparam logic [1:0]  CSDS_STRAP_S16  = 2'h3;
    localparam logic [3:0]  CSDS_WAIT_NONE  = 4'h0;
    localparam logic [3:0]  CSDS_WAIT_BOOT  = 4'hf;
    localparam logic [1:0]  CSDS_SETTLE     = 2'h3;
    localparam logic [1:0]  CSDS_PINF_RST   = 2'h3;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        CSDS_IDLE = 4'b0001,
        CSDS_ROW  = 4'b0010,
        CSDS_WAIT = 4'b0100,
        CSDS_COL  = 4'b1000
    } csds_phase_e;

    typedef struct packed {
        logic [19:0] start;
        logic [19:0] mask;
        logic [3:0]  wait_n;
        logic [1:0]  port_width_code;
        logic        dram;
        logic        en;
    } csds_region_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic [1:0]  size;
        logic        big_end;
    } csds_req_s;

    typedef struct packed {
        logic [4:0]  sel_n;
        logic [3:0]  col_n;
        logic        rd_n;
        logic        wr_n;
        logic        dir;
        logic [27:0] addr;
    } csds_pins_s;

    typedef struct packed {
        csds_region_s [4:0] rgn;
        logic [1:0]         pinf;
        logic [2:0][1:0]    strap;
        logic [1:0]         settle;
        logic               boot_pend;
        csds_phase_e        phase;
        logic [3:0]         cnt;
        logic [2:0]         cur;
        logic [3:0]         lanes;
        logic               dram;
        logic [27:0]        maddr;
        logic [4:0]         sel_n;
        logic [3:0]         col_n;
        logic               rd_n;
        logic               wr_n;
        logic               dir;
        logic               done;
        logic               miss;
        logic [31:0]        rdata;
    } csds_state_s;

endpackage : csds_pkg

//--- rtl/csds_top.sv
// region select decode, boot straps and memory strobes
`timescale 1ns/1ps
// Summary of operation
// R1: five active-low region selects, low while an access hits that region
// R2: each region has its own range and DRAM or SRAM timing
// R3: a DRAM region's select acts as row strobe, low with row address
// R4: hit when address AND mask equals start AND mask over bits 31..12
// R5: bits 11..0 never decoded; zero mask bits are ignored
// R6: non-contiguous masks give several separated windows per region
// R7: straps on lines 24/23 sampled at power-up configure region 0
// R8: straps load pin functions, enable, wait, width; 00 leaves disabled
// R9: strap 01 gives 32-bit SRAM, wait 1111, address pins kept
// R10: strap 10 gives 32-bit page DRAM, wait 1111, address pins kept
// R11: strap 11 gives 16-bit SRAM, wait 1111, pins become region-0 strobes
// R12: column strobes only for DRAM regions, low with column address
// R13: 32-bit port lane mapping for bytes and halfwords by endianness
// R14: 16-bit port uses column strobes 3 and 2 only
// R15: 8-bit port uses column strobe 3 only
// R16: direction high for reads, low for writes
// R17: read strobe low while a read cycle runs
// R18: write strobe low while a write cycle runs
// R19: width code 00 32-bit, 01 16-bit, 10 8-bit, 11 32-bit same as 00
// R20: every cycle lasts 2 clocks plus 0..15 wait clocks
// R21: top two address pins carry address only when function bit is 1
// R22: straps captured around reset and applied before the first access
// R23: overlapping hits assert only the lowest numbered select
module csds_top
(
    // clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output      logic [31:0]           reg_rdata,
    // access request from processor or dma
    input  csds_pkg::csds_req_s        req,
    output      logic                  req_ready,
    output      logic                  req_done,
    output      logic                  req_miss,
    // boot straps from address lines 24 and 23
    input  wire logic [1:0]            strap_pins,
    // memory pins
    output csds_pkg::csds_pins_s       mem
);
    import csds_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    csds_state_s st_ff;
    csds_state_s nxt_st;
    logic [4:0]  hit;
    logic [2:0]  pick;
    logic        found;
    logic [2:0]  ridx;
    logic        boot_rd_n;
    logic        boot_wr_n;

    // -----------------------------------------------------------------
    // region match, one comparator per region
    // -----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CSDS_NREG; g++)
        begin : g_hit
            // low twelve bits never enter the compare
            assign hit[g] = st_ff.rgn[g].en &&                        // R4 R5
                ((req.addr[31:CSDS_F_HI_LO] & st_ff.rgn[g].mask) ==
                 (st_ff.rgn[g].start & st_ff.rgn[g].mask));           // R6
        end
    endgenerate

    // -----------------------------------------------------------------
    // lane selection for the column strobes
    // -----------------------------------------------------------------
    function automatic logic [3:0] lanes_for
    (
        input logic [1:0] pw,
        input logic [1:0] sz,
        input logic [1:0] a,
        input logic       be
    );
        logic [3:0] ln;
        logic [1:0] ix;
        ln = 4'h0;
        ix = be ? ~a : a;
        case (pw)
            CSDS_PW_8:
                ln = 4'h8;                                             // R15
            CSDS_PW_16:
                if (sz == CSDS_SZ_BYTE)
                    ln = (a[0] ^ be) ? 4'h8 : 4'h4;                    // R14
                else
                    ln = 4'hc;                                         // R14
            default:
                // width codes 00 and 11 are both 32-bit lanes
                if (sz == CSDS_SZ_WORD)
                    ln = 4'hf;                                         // R13
                else if (sz == CSDS_SZ_HALF)
                    ln = (a[1] ^ be) ? 4'hc : 4'h3;                    // R13
                else
                    ln = 4'h1 << ix;                                   // R13
        endcase
        return ln;
    endfunction : lanes_for

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        pick   = 3'h0;
        found  = 1'b0;
        ridx   = reg_addr[CSDS_IDX_HI:CSDS_IDX_LO];

        // scanning downward leaves the lowest hit in pick
        for (int i = CSDS_NREG - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                pick  = 3'(i);                                         // R23
                found = 1'b1;
            end
        end

        nxt_st.done = 1'b0;
        nxt_st.miss = 1'b0;

        // register writes
        if (reg_wr)
        begin
            if (reg_addr < CSDS_OFS_RGN_END && ridx < CSDS_NREG_L)
            begin
                if (!reg_addr[CSDS_SEL_OPT])
                begin
                    nxt_st.rgn[ridx].start =
                        reg_wdata[31:CSDS_F_HI_LO];                    // R2
                    nxt_st.rgn[ridx].en    = reg_wdata[CSDS_F_EN];
                end
                else
                begin
                    nxt_st.rgn[ridx].mask   = reg_wdata[31:CSDS_F_HI_LO];
                    nxt_st.rgn[ridx].wait_n =
                        reg_wdata[CSDS_F_WT_HI:CSDS_F_WT_LO];
                    nxt_st.rgn[ridx].port_width_code =
                        reg_wdata[CSDS_F_PW_HI:CSDS_F_PW_LO];          // R19
                    nxt_st.rgn[ridx].dram = reg_wdata[CSDS_F_DRAM];    // R2
                end
            end
            else if (reg_addr == CSDS_OFS_CTRL)
            begin
                nxt_st.pinf = {reg_wdata[CSDS_F_TOPF],
                               reg_wdata[CSDS_F_SECF]};
            end
        end

        // register reads, answered in the following cycle
        if (reg_rd)
        begin
            nxt_st.rdata = 32'h0;
            if (reg_addr < CSDS_OFS_RGN_END && ridx < CSDS_NREG_L)
            begin
                if (!reg_addr[CSDS_SEL_OPT])
                    nxt_st.rdata = {st_ff.rgn[ridx].start, 11'h0,
                                    st_ff.rgn[ridx].en};
                else
                    nxt_st.rdata = {st_ff.rgn[ridx].mask,
                                    st_ff.rgn[ridx].wait_n, 3'h0,
                                    st_ff.rgn[ridx].dram,
                                    st_ff.rgn[ridx].port_width_code,
                                    2'h0};
            end
            else if (reg_addr == CSDS_OFS_CTRL)
            begin
                nxt_st.rdata = {30'h0, st_ff.pinf};
            end
            else if (reg_addr == CSDS_OFS_STAT)
            begin
                nxt_st.rdata = {20'h0, st_ff.boot_pend, st_ff.cur,
                                st_ff.phase, st_ff.sel_n[3:0]};
            end
        end

        // strap synchroniser: only stages two and three are compared
        nxt_st.strap = {st_ff.strap[1], st_ff.strap[0], strap_pins};   // R7
        if (st_ff.boot_pend)
        begin
            if (st_ff.settle != CSDS_SETTLE)
                nxt_st.settle = st_ff.settle + 2'h1;
            else if (st_ff.strap[1] == st_ff.strap[2])
            begin
                nxt_st.boot_pend = 1'b0;                               // R22
                nxt_st.rgn[0].en = (st_ff.strap[2] != CSDS_STRAP_OFF); // R8
                nxt_st.rgn[0].dram =
                    (st_ff.strap[2] == CSDS_STRAP_DRAM);               // R10
                nxt_st.rgn[0].wait_n =
                    (st_ff.strap[2] == CSDS_STRAP_OFF) ?
                    CSDS_WAIT_NONE : CSDS_WAIT_BOOT;                   // R9
                nxt_st.rgn[0].port_width_code =
                    (st_ff.strap[2] == CSDS_STRAP_S16) ?
                    CSDS_PW_16 : CSDS_PW_32;                           // R11
                nxt_st.pinf =
                    (st_ff.strap[2] == CSDS_STRAP_S16) ?
                    2'h0 : CSDS_PINF_RST;                              // R11
            end
        end

        // memory cycle sequencer
        case (st_ff.phase)
            CSDS_IDLE:
            begin
                if (req.valid && req_ready)
                begin
                    if (found)
                    begin
                        nxt_st.phase = CSDS_ROW;
                        nxt_st.cur   = pick;
                        nxt_st.cnt   = st_ff.rgn[pick].wait_n;         // R20
                        nxt_st.dram  = st_ff.rgn[pick].dram;
                        nxt_st.lanes = lanes_for(
                            st_ff.rgn[pick].port_width_code, req.size,
                            req.addr[1:0], req.big_end);
                        nxt_st.maddr = req.addr[27:0];
                        nxt_st.sel_n = ~(5'h1 << pick);                // R1 R3
                        nxt_st.dir   = ~req.write;                     // R16
                        nxt_st.rd_n  = req.write;                      // R17
                        nxt_st.wr_n  = ~req.write;                     // R18
                    end
                    else
                    begin
                        nxt_st.done = 1'b1;
                        nxt_st.miss = 1'b1;
                    end
                end
            end
            CSDS_ROW:
            begin
                if (st_ff.cnt == 4'h0)
                begin
                    nxt_st.phase = CSDS_COL;
                    nxt_st.col_n = st_ff.dram ? ~st_ff.lanes : 4'hf; // R12
                end
                else
                begin
                    nxt_st.phase = CSDS_WAIT;
                end
            end
            CSDS_WAIT:
            begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                if (st_ff.cnt == 4'h1)
                begin
                    nxt_st.phase = CSDS_COL;
                    nxt_st.col_n = st_ff.dram ? ~st_ff.lanes : 4'hf; // R12
                end
            end
            CSDS_COL:
            begin
                // the cycle ends here: two clocks plus the wait count
                nxt_st.phase = CSDS_IDLE;                              // R20
                nxt_st.done  = 1'b1;
                nxt_st.sel_n = 5'h1f;
                nxt_st.col_n = 4'hf;
                nxt_st.rd_n  = 1'b1;
                nxt_st.wr_n  = 1'b1;
                nxt_st.dir   = 1'b1;
            end
            default:
            begin
                nxt_st.phase = CSDS_IDLE;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff           <= '0;
            st_ff.pinf      <= CSDS_PINF_RST;
            st_ff.boot_pend <= 1'b1;
            st_ff.phase     <= CSDS_IDLE;
            st_ff.sel_n     <= 5'h1f;
            st_ff.col_n     <= 4'hf;
            st_ff.rd_n      <= 1'b1;
            st_ff.wr_n      <= 1'b1;
            st_ff.dir       <= 1'b1;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // no access is taken until the straps have landed in region 0
    assign req_ready = ce && (st_ff.phase == CSDS_IDLE) &&
                       !st_ff.boot_pend;                               // R22
    assign req_done  = st_ff.done;
    assign req_miss  = st_ff.miss;
    assign reg_rdata = st_ff.rdata;

    assign boot_rd_n = (st_ff.sel_n[0] == 1'b0) ? st_ff.rd_n : 1'b1;
    assign boot_wr_n = (st_ff.sel_n[0] == 1'b0) ? st_ff.wr_n : 1'b1;

    assign mem.sel_n = st_ff.sel_n;
    assign mem.col_n = st_ff.col_n;
    assign mem.rd_n  = st_ff.rd_n;
    assign mem.wr_n  = st_ff.wr_n;
    assign mem.dir   = st_ff.dir;
    assign mem.addr  = {
        st_ff.pinf[1] ? st_ff.maddr[27] : boot_rd_n,                   // R21
        st_ff.pinf[0] ? st_ff.maddr[26] : boot_wr_n,                   // R21
        st_ff.maddr[25:0]};

endmodule : csds_top

//--- sim/csds_checker_assertions.sv
// pin-level checks for the region select decode and strobe block
`timescale 1ns/1ps
module csds_checker
(
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 resetn,
    input wire logic                 ce,
    // request side
    input wire csds_pkg::csds_req_s  req,
    input wire logic                 req_ready,
    input wire logic                 req_done,
    input wire logic                 req_miss,
    // memory pins
    input wire csds_pkg::csds_pins_s mem
);
    import csds_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // ----------
    // sequences
    // ----------
    sequence s_col_start;
        $fell(mem.col_n == 4'hf);
    endsequence
    sequence s_cycle_end;
        $rose(mem.rd_n && mem.wr_n);
    endsequence

    a_row_first: assert property (s_col_start |->
        mem.sel_n != 5'h1f && $past(mem.sel_n) != 5'h1f)
        else $error("column strobe without a row strobe before it");
    a_end_done: assert property (s_cycle_end |-> req_done)
        else $error("cycle ended without done");
    a_min_two: assert property ($fell(mem.rd_n && mem.wr_n)
        |=> !(mem.rd_n && mem.wr_n))
        else $error("memory cycle shorter than two clocks");
    a_done_pins: assert property (req_done && !req_miss
        |-> !$past(mem.rd_n && mem.wr_n))
        else $error("done without a preceding memory cycle");
    a_dir_read: assert property (!mem.rd_n |-> mem.dir)
        else $error("direction low during read");
    a_dir_write: assert property (!mem.wr_n
        |-> !mem.dir && mem.rd_n)
        else $error("direction or read strobe wrong during write");
    a_one_select: assert property ($onehot0(~mem.sel_n))
        else $error("more than one region select low");
    a_sel_strobe: assert property (mem.sel_n != 5'h1f
        |-> !(mem.rd_n && mem.wr_n))
        else $error("select low outside a memory cycle");
    a_boot_wait: assert property ($rose(resetn)
        |-> !req_ready [*4])
        else $error("ready before the straps settled");
    a_ready_ce: assert property (!ce |-> !req_ready
        ##1 ($stable(mem) && $stable(req_done)))
        else $error("ready or pins moved while clock enable low");
    a_miss_quiet: assert property (req_miss
        |-> req_done && mem.sel_n == 5'h1f)
        else $error("miss with a select low or without done");
endmodule : csds_checker

//--- sim/csds_mem_model.sv
// memory-side model: folds what each memory cycle showed on the pins
`timescale 1ns/1ps
module csds_mem_model
(
    // clock
    input wire logic                 clk_sys,
    // memory pins
    input wire csds_pkg::csds_pins_s mem
);
    import csds_pkg::*;
    logic       act_q = 1'b0;
    logic [4:0] sel;
    logic [3:0] col;
    logic [1:0] ab;
    logic       dir, rd, wr;
    int         len;

    // a cycle lasts while either strobe is low; low levels are kept by AND
    always @(posedge clk_sys)
    begin
        if (!(mem.rd_n && mem.wr_n))
        begin
            if (!act_q)
                {sel, col, ab, dir, rd, wr, len} = {14'h3fff, 32'h0};
            len = len + 1;
            sel &= mem.sel_n;
            col &= mem.col_n;
            ab &= mem.addr[27:26];
            dir &= mem.dir;
            rd &= mem.rd_n;
            wr &= mem.wr_n;
        end
        act_q = !(mem.rd_n && mem.wr_n);
    end
endmodule : csds_mem_model

//--- sim/csds_top_tb_top.sv
// self-checking testbench for the region select decode and strobe block
`timescale 1ns/1ps
module csds_top_tb_top;
    import csds_pkg::*;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, d;
    logic [1:0]  strap_pins = 2'h0;
    csds_req_s   req = '0;
    csds_pins_s  mem;
    logic        req_ready, req_done, req_miss, miss;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [31:0] na [6] = '{32'h4000_0000, 32'h4400_0000, 32'h48ab_c000,
                            32'h4c00_0fff, 32'h5000_0000, 32'h4100_0000};

    csds_top dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
        .req_ready(req_ready), .req_done(req_done), .req_miss(req_miss),
        .strap_pins(strap_pins), .mem(mem));
    csds_mem_model u_mem (.clk_sys(clk_sys), .mem(mem));

    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic results;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_cyc(input logic [4:0] s, input int l,
                           input logic [3:0] c, input logic w);
        chk(32'(u_mem.sel), 32'(s));
        chk(32'(u_mem.len), 32'(l));
        chk(32'(u_mem.col), 32'(c));
        chk(32'({u_mem.dir, u_mem.rd, u_mem.wr}), 32'({!w, w, !w}));
    endtask : chk_cyc

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd_reg

    // request held until sampled with ready, then wait for done
    task automatic acc(input logic [31:0] a, input logic w,
                       input logic [1:0] sz, input logic be);
        int n;
        @(posedge clk_sys);
        req <= '{1'b1, a, w, sz, be};
        n = 0;
        do @(negedge clk_sys); while (req_ready !== 1'b1 && ++n < 100);
        @(posedge clk_sys);
        req.valid <= 1'b0;
        do @(negedge clk_sys); while (req_done !== 1'b1 && ++n < 200);
        chk(32'(n < 200), 32'h1);
        miss = req_miss;
    endtask : acc

    task automatic do_reset(input logic [1:0] s);
        int n;
        @(posedge clk_sys);
        strap_pins <= s;
        resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        n = 0;
        do @(negedge clk_sys); while (req_ready !== 1'b1 && ++n < 50);
        chk(32'(n < 50), 32'h1);
    endtask : do_reset

    // big-endian numbers the byte lanes from the other end
    function automatic logic [3:0] lanes(input int p, input logic [1:0] sz,
                                         input logic [1:0] a, input logic be);
        logic [1:0] b;
        b = be ? ~a : a;
        if (p == 2) return 4'h8;
        if (p == 1) return (sz != CSDS_SZ_BYTE) ? 4'hc : (b[0] ? 4'h8 : 4'h4);
        if (sz == CSDS_SZ_WORD) return 4'hf;
        if (sz == CSDS_SZ_HALF) return b[1] ? 4'hc : 4'h3;
        return 4'h1 << b;
    endfunction : lanes

    initial
    begin
        #(40 * 30000);
        $display("ERROR %0t watchdog expired", $time);
        error_cnt++;
        results();
    end

    initial
    begin
        logic [1:0] sz, a;
        logic       be;
        // ----------
        // boot straps, strap 00 last so region 0 stays off
        // ----------
        for (int s = 3; s >= 0; s--)
        begin
            do_reset(2'(s));
            rd_reg(8'h00, d);
            chk(d, 32'(s != 0));
            rd_reg(8'h04, d);
            chk(d, {20'h0, (s != 0) ? 4'hf : 4'h0, 3'h0, s == 2,
                (s == 3) ? CSDS_PW_16 : CSDS_PW_32, 2'h0});
            rd_reg(8'h28, d);
            chk(d, (s == 3) ? 32'h0 : 32'h3);
            acc(32'h0c00_0123, 1'b0, CSDS_SZ_WORD, 1'b0);
            chk(32'(miss), 32'(s == 0));
            if (s != 0)
                chk_cyc(5'h1e, 17, (s == 2) ? 4'h0 : 4'hf, 1'b0);
            if (s == 3)
            begin
                chk(32'(u_mem.ab), 32'h1);
                acc(32'h0c00_0123, 1'b1, CSDS_SZ_WORD, 1'b0);
                chk(32'(u_mem.ab), 32'h2);
            end
        end
        // ----------
        // sram waits, dram lanes, priority, gapped mask
        // ----------
        wr_reg(8'h08, 32'h0001_0001);
        rd_reg(8'h08, d);
        chk(d, 32'h0001_0001);
        for (int w = 0; w < 16; w = w * 2 + 1)
        begin
            wr_reg(8'h0c, {20'hfffff, 4'(w), 8'h0});
            acc(32'h0001_0ffc, w[1], CSDS_SZ_WORD, 1'b0);
            chk_cyc(5'h1d, 2 + w, 4'hf, w[1]);
        end
        wr_reg(8'h10, 32'h0002_0001);
        for (int p = 0; p < 4; p++)
        begin
            wr_reg(8'h14, {20'hfffff, 4'h0, 4'h1, 2'(p), 2'h0});
            for (int k = 0; k < 24; k++)
            begin
                sz = 2'(k / 8);
                a = 2'(k >> 1);
                be = k[0];
                if (!((sz == CSDS_SZ_HALF && a[0]) ||
                      (sz == CSDS_SZ_WORD && a != 2'h0)))
                begin
                    acc(32'h0002_0000 | 32'(a), be, sz, be);
                    chk_cyc(5'h1b, 2, ~lanes(p, sz, a, be), be);
                end
            end
        end
        wr_reg(8'h18, 32'h0001_0001);
        wr_reg(8'h1c, 32'hffff_f000);
        acc(32'h0001_0abc, 1'b0, CSDS_SZ_BYTE, 1'b0);
        chk_cyc(5'h1d, 17, 4'hf, 1'b0);
        wr_reg(8'h08, 32'h0001_0000);
        acc(32'h0001_0abc, 1'b0, CSDS_SZ_BYTE, 1'b0);
        chk_cyc(5'h17, 2, 4'hf, 1'b0);
        wr_reg(8'h20, 32'h4000_0001);
        wr_reg(8'h24, 32'hf300_0000);
        // top pin turns strobe, second pin keeps its address bit
        wr_reg(8'h28, 32'h1);
        rd_reg(8'h28, d);
        chk(d, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            acc(na[i], 1'b0, CSDS_SZ_WORD, 1'b0);
            chk(32'(miss), 32'(i >= 4));
            if (i < 4)
            begin
                chk(32'(u_mem.sel), 32'h0f);
                chk(32'(u_mem.ab), 32'({1'b1, na[i][26]}));
            end
        end
        rd_reg(8'h30, d);
        chk(d, 32'h0);
        rd_reg(8'h2c, d);
        chk(d, {20'h0, 1'b0, 3'h4, 4'h1, 4'hf});
        @(posedge clk_sys);
        ce <= 1'b0;
        @(negedge clk_sys);
        chk(32'(req_ready), 32'h0);
        @(posedge clk_sys);
        ce <= 1'b1;
        results();
    end
endmodule : csds_top_tb_top

bind csds_top csds_checker u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .req(req),
    .req_ready(req_ready), .req_done(req_done), .req_miss(req_miss),
    .mem(mem));
